// >>> verilog/ocr_defs.svh
// Offsets, field positions, reset values and codes of the fault block
`ifndef OCR_DEFS_SVH
`define OCR_DEFS_SVH

// ****************************************************************
// Serial bus addressing
// ****************************************************************
`define OCR_DEV_ADDR 7'h20
`define OCR_CMD_LIMIT 8'h46
`define OCR_CMD_SETUP 8'h47

// ****************************************************************
// Register reset values
// ****************************************************************
`define OCR_LIMIT_RST 16'h0000
`define OCR_SETUP_RST 8'hc0

// ****************************************************************
// Reaction setup fields
// ****************************************************************
`define OCR_RESP_HI 7
`define OCR_RESP_LO 6
`define OCR_RETRY_HI 5
`define OCR_RETRY_LO 3
`define OCR_DELAY_HI 2
`define OCR_DELAY_LO 0
`define OCR_RETRY_NONE 3'h0
`define OCR_RETRY_FOREVER 3'h7
`define OCR_DELAY_ONE 8'h01

// Linear format mantissa span and bit count of a bus byte
`define OCR_MANT_HI 10
`define OCR_BIT_LAST 4'h8

`endif

// >>> verilog/ocr_pkg.sv
// Types of the overcurrent fault response block
package ocr_pkg;

    // ****************************************************************
    // Reaction codes and state machines
    // ****************************************************************
    typedef enum logic [1:0] {
        RESP_IGNORE = 2'b00,
        RESP_COND = 2'b01,
        RESP_DELAY = 2'b10,
        RESP_SHUT = 2'b11
    } ocr_resp_t;

    typedef enum logic [2:0] {
        F_RUN = 3'b000,
        F_LIMIT = 3'b001,
        F_WAIT = 3'b010,
        F_LATCH = 3'b011,
        F_OFF = 3'b100
    } ocr_fstate_t;

    typedef enum logic [2:0] {
        B_IDLE = 3'b000,
        B_RX = 3'b001,
        B_ACK = 3'b010,
        B_TX = 3'b011,
        B_RACK = 3'b100
    } ocr_bstate_t;

    // ****************************************************************
    // Converter side carriers
    // ****************************************************************
    typedef struct packed {
        logic [15:0] current;
        logic voltLow;
        logic enableCmd;
        logic faultClear;
        logic otherFault;
        logic unitTick;
    } ocr_plant_in_t;

    typedef struct packed {
        logic outputEnable;
        logic currentLimit;
        logic ocFault;
        logic alertOut;
        logic alertDriveB;
    } ocr_plant_out_t;

    // ****************************************************************
    // Whole state of the block
    // ****************************************************************
    typedef struct packed {
        logic [1:0] clkSync;
        logic [1:0] datSync;
        logic clkLast;
        logic datLast;
        ocr_bstate_t bst;
        logic [3:0] bitCnt;
        logic [1:0] byteNum;
        logic readMode;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [7:0] cmd;
        logic [7:0] limitLow;
        logic readIdx;
        logic masterAck;
        logic dataDriveB;
        logic [15:0] limit;
        logic [7:0] setup;
        ocr_fstate_t fst;
        logic [7:0] delayCnt;
        logic [2:0] attempts;
        ocr_plant_out_t out;
    } ocr_state_t;

endpackage

// >>> verilog/ocr_fault_response.sv
// Overcurrent fault response with its serial bus register port
`timescale 1ns/1ps
`include "ocr_defs.svh"

module ocr_fault_response (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pmbClkPin,
    input wire logic pmbDataIn,
    output logic pmbDataOut,
    output logic pmbDataDriveB,
    input wire ocr_pkg::ocr_plant_in_t plantIn,
    output ocr_pkg::ocr_plant_out_t plantOut
);

    ocr_pkg::ocr_state_t s_q;
    ocr_pkg::ocr_state_t s_d;

    logic clkRise;
    logic clkFall;
    logic startSeen;
    logic stopSeen;
    logic overCurrent;
    logic [7:0] delayUnits;
    logic [2:0] retryField;
    ocr_pkg::ocr_resp_t resp;

    // ****************************************************************
    // Decoded settings and line events
    // ****************************************************************

    // Edges come only from the second sync stage and its copy
    assign clkRise = s_q.clkSync[1] & ~s_q.clkLast;
    assign clkFall = ~s_q.clkSync[1] & s_q.clkLast;
    assign startSeen = s_q.clkSync[1] & s_q.clkLast
                       & s_q.datLast & ~s_q.datSync[1];
    assign stopSeen = s_q.clkSync[1] & s_q.clkLast
                      & ~s_q.datLast & s_q.datSync[1];

    // Mantissas compared directly; both sides share one exponent
    assign overCurrent = $signed(plantIn.current[`OCR_MANT_HI:0])
                         > $signed(s_q.limit[`OCR_MANT_HI:0]);

    // Power-of-two unit count from the three-bit code
    assign delayUnits = `OCR_DELAY_ONE
                        << s_q.setup[`OCR_DELAY_HI:`OCR_DELAY_LO];
    assign retryField = s_q.setup[`OCR_RETRY_HI:`OCR_RETRY_LO];
    assign resp = ocr_pkg::ocr_resp_t'(s_q.setup[`OCR_RESP_HI:`OCR_RESP_LO]);

    assign pmbDataOut = 1'b0;
    assign pmbDataDriveB = s_q.dataDriveB;
    assign plantOut = s_q.out;

    // ****************************************************************
    // Next state: bus slave and fault sequencer
    // ****************************************************************

    // Shutdown decision is shared by several reaction paths
    function automatic ocr_pkg::ocr_state_t shut_down(
        input ocr_pkg::ocr_state_t st,
        input logic [2:0] retries,
        input logic [7:0] units
    );
        ocr_pkg::ocr_state_t r;
        r = st;
        r.out.outputEnable = 1'b0;
        r.out.currentLimit = 1'b0;
        if (retries == `OCR_RETRY_NONE) begin
            r.fst = ocr_pkg::F_LATCH;
        end else if (retries != `OCR_RETRY_FOREVER
                     && st.attempts >= retries) begin
            r.fst = ocr_pkg::F_LATCH;
        end else begin
            r.fst = ocr_pkg::F_WAIT;
            r.delayCnt = units;
            if (retries != `OCR_RETRY_FOREVER) begin
                r.attempts = st.attempts + 3'h1;
            end
        end
        return r;
    endfunction

    always_comb begin
        s_d = s_q;
        // Two-stage pin synchronisers
        s_d.clkSync = {s_q.clkSync[0], pmbClkPin};
        s_d.datSync = {s_q.datSync[0], pmbDataIn};
        s_d.clkLast = s_q.clkSync[1];
        s_d.datLast = s_q.datSync[1];

        // Bus slave: start and stop override any byte in flight
        if (startSeen) begin
            s_d.bst = ocr_pkg::B_RX;
            s_d.bitCnt = 4'h0;
            s_d.byteNum = 2'h0;
            s_d.dataDriveB = 1'b1;
        end else if (stopSeen) begin
            s_d.bst = ocr_pkg::B_IDLE;
            s_d.dataDriveB = 1'b1;
        end else begin
            unique case (s_q.bst)
                ocr_pkg::B_IDLE: begin
                    s_d.dataDriveB = 1'b1;
                end
                ocr_pkg::B_RX: begin
                    if (clkRise && s_q.bitCnt != `OCR_BIT_LAST) begin
                        s_d.shiftIn = {s_q.shiftIn[6:0], s_q.datSync[1]};
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end else if (clkFall
                                 && s_q.bitCnt == `OCR_BIT_LAST) begin
                        s_d.bst = ocr_pkg::B_ACK;
                        s_d.dataDriveB = 1'b0;
                        if (s_q.byteNum == 2'h0) begin
                            if (s_q.shiftIn[7:1] == `OCR_DEV_ADDR) begin
                                s_d.readMode = s_q.shiftIn[0];
                                s_d.readIdx = 1'b0;
                            end else begin
                                s_d.bst = ocr_pkg::B_IDLE;
                                s_d.dataDriveB = 1'b1;
                            end
                        end else if (s_q.byteNum == 2'h1) begin
                            s_d.cmd = s_q.shiftIn;
                        end else if (s_q.byteNum == 2'h2) begin
                            if (s_q.cmd == `OCR_CMD_SETUP) begin
                                s_d.setup = s_q.shiftIn;
                            end
                            s_d.limitLow = s_q.shiftIn;
                        end else if (s_q.cmd == `OCR_CMD_LIMIT) begin
                            // Word takes effect only once whole
                            s_d.limit = {s_q.shiftIn, s_q.limitLow};
                        end
                        if (s_q.byteNum != 2'h3) begin
                            s_d.byteNum = s_q.byteNum + 2'h1;
                        end
                    end
                end
                ocr_pkg::B_ACK: begin
                    if (clkFall) begin
                        s_d.bitCnt = 4'h0;
                        if (s_q.readMode) begin
                            s_d.bst = ocr_pkg::B_TX;
                            s_d.shiftOut = (s_q.cmd == `OCR_CMD_SETUP)
                                ? s_q.setup
                                : (s_q.cmd == `OCR_CMD_LIMIT)
                                ? s_q.limit[7:0] : 8'h00;
                            s_d.dataDriveB = (s_q.cmd == `OCR_CMD_SETUP)
                                ? s_q.setup[7]
                                : (s_q.cmd == `OCR_CMD_LIMIT)
                                ? s_q.limit[7] : 1'b0;
                        end else begin
                            s_d.bst = ocr_pkg::B_RX;
                            s_d.dataDriveB = 1'b1;
                        end
                    end
                end
                ocr_pkg::B_TX: begin
                    if (clkFall) begin
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                        s_d.shiftOut = {s_q.shiftOut[6:0], 1'b0};
                        if (s_q.bitCnt == 4'h7) begin
                            s_d.bst = ocr_pkg::B_RACK;
                            s_d.dataDriveB = 1'b1;
                        end else begin
                            s_d.dataDriveB = s_q.shiftOut[6];
                        end
                    end
                end
                ocr_pkg::B_RACK: begin
                    if (clkRise) begin
                        s_d.masterAck = ~s_q.datSync[1];
                    end else if (clkFall) begin
                        // Master nack ends the read
                        if (s_q.masterAck) begin
                            s_d.bst = ocr_pkg::B_TX;
                            s_d.bitCnt = 4'h0;
                            s_d.readIdx = 1'b1;
                            s_d.shiftOut = (s_q.cmd == `OCR_CMD_LIMIT
                                            && !s_q.readIdx)
                                ? s_q.limit[15:8] : 8'h00;
                            s_d.dataDriveB = (s_q.cmd == `OCR_CMD_LIMIT
                                              && !s_q.readIdx)
                                ? s_q.limit[15] : 1'b0;
                        end else begin
                            s_d.bst = ocr_pkg::B_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.bst = ocr_pkg::B_IDLE;
                    s_d.dataDriveB = 1'b1;
                end
            endcase
        end

        // Fault sequencer; command off and other faults win first
        if (!plantIn.enableCmd || plantIn.otherFault) begin
            s_d.fst = ocr_pkg::F_OFF;
            s_d.out.outputEnable = 1'b0;
            s_d.out.currentLimit = 1'b0;
            s_d.attempts = 3'h0;
        end else begin
            unique case (s_q.fst)
                ocr_pkg::F_RUN: begin
                    s_d.out.outputEnable = 1'b1;
                    if (overCurrent) begin
                        if (resp == ocr_pkg::RESP_SHUT) begin
                            s_d = shut_down(s_d, retryField,
                                            delayUnits);
                        end else begin
                            s_d.fst = ocr_pkg::F_LIMIT;
                            s_d.out.currentLimit = 1'b1;
                            s_d.delayCnt = delayUnits;
                        end
                    end
                end
                ocr_pkg::F_LIMIT: begin
                    if (!overCurrent) begin
                        s_d.fst = ocr_pkg::F_RUN;
                        s_d.out.currentLimit = 1'b0;
                    end else if (resp == ocr_pkg::RESP_COND
                                 && plantIn.voltLow) begin
                        s_d = shut_down(s_d, retryField,
                                        delayUnits);
                    end else if (resp == ocr_pkg::RESP_SHUT) begin
                        s_d = shut_down(s_d, retryField, delayUnits);
                    end else if (resp == ocr_pkg::RESP_DELAY
                                 && plantIn.unitTick) begin
                        if (s_q.delayCnt == `OCR_DELAY_ONE) begin
                            s_d = shut_down(s_d, retryField,
                                            delayUnits);
                        end else begin
                            s_d.delayCnt = s_q.delayCnt - 8'h01;
                        end
                    end
                end
                ocr_pkg::F_WAIT: begin
                    // Spacing between restart attempts
                    if (plantIn.unitTick) begin
                        if (s_q.delayCnt == `OCR_DELAY_ONE) begin
                            s_d.fst = ocr_pkg::F_RUN;
                            s_d.out.outputEnable = 1'b1;
                        end else begin
                            s_d.delayCnt = s_q.delayCnt - 8'h01;
                        end
                    end
                end
                ocr_pkg::F_LATCH: begin
                    if (plantIn.faultClear) begin
                        s_d.fst = ocr_pkg::F_RUN;
                        s_d.attempts = 3'h0;
                    end
                end
                ocr_pkg::F_OFF: begin
                    s_d.fst = ocr_pkg::F_RUN;
                end
                default: begin
                    s_d.fst = ocr_pkg::F_OFF;
                end
            endcase
        end

        // Sticky status and alert; a new fault beats a clear
        if (overCurrent) begin
            s_d.out.ocFault = 1'b1;
        end else if (plantIn.faultClear) begin
            s_d.out.ocFault = 1'b0;
        end
        s_d.out.alertOut = 1'b0;
        s_d.out.alertDriveB = ~s_d.out.ocFault;
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset leaves the output off until the sequencer is enabled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.clkSync <= 2'h3;
            s_q.datSync <= 2'h3;
            s_q.clkLast <= 1'b1;
            s_q.datLast <= 1'b1;
            s_q.bst <= ocr_pkg::B_IDLE;
            s_q.dataDriveB <= 1'b1;
            s_q.limit <= `OCR_LIMIT_RST;
            s_q.setup <= `OCR_SETUP_RST;
            s_q.fst <= ocr_pkg::F_OFF;
            s_q.out.alertDriveB <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// >>> sim/ocr_bus_host.sv
// Serial bus host model for the register port of the fault block
`timescale 1ns/1ps
`include "ocr_defs.svh"
module ocr_bus_host (
    input wire logic core_clk,
    input wire logic pmbDataOut,
    input wire logic pmbDataDriveB,
    output logic pmbClkPin,
    output logic pmbDataIn
);
    logic hostSda;
    // ****************************************
    // Wire level and bit timing
    // ****************************************
    // Pulled-up line, low while any party drives it
    assign pmbDataIn = hostSda & (pmbDataDriveB | pmbDataOut);
    // Bus idles released with the clock standing high
    initial begin
        pmbClkPin = 1'b1;
        hostSda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Ten core cycles a bit: 80 ns, data only moves while clock is low
    task automatic bitx(input logic b, output logic r);
        tick(2);
        hostSda <= b;
        tick(4);
        pmbClkPin <= 1'b1;
        tick(2);
        r = pmbDataIn;
        tick(2);
        pmbClkPin <= 1'b0;
    endtask
    // Late rise leaves the device time to drop its acknowledge
    task automatic start();
        tick(2);
        hostSda <= 1'b1;
        tick(4);
        pmbClkPin <= 1'b1;
        tick(3);
        hostSda <= 1'b0;
        tick(3);
        pmbClkPin <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        hostSda <= 1'b0;
        tick(4);
        pmbClkPin <= 1'b1;
        tick(3);
        hostSda <= 1'b1;
        tick(5);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic hAck,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(hAck, ack);
    endtask
    // Write of one or two bytes, low byte first; ok low on any nack
    task automatic wr(input logic [6:0] adr, input logic [7:0] cmd,
                      input logic [15:0] dat, input int n, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        xfer({adr, 1'b0}, 1'b1, rx, a0);
        xfer(cmd, 1'b1, rx, a1);
        xfer(dat[7:0], 1'b1, rx, a2);
        a3 = 1'b0;
        if (n == 2) xfer(dat[15:8], 1'b1, rx, a3);
        stop();
        ok = !(a0 | a1 | a2 | a3);
    endtask
    // Read after repeated start; the host nacks the last byte
    task automatic rd(input logic [7:0] cmd, input int n,
                      output logic [15:0] dat);
        logic a;
        logic [7:0] rx;
        dat = 16'h0000;
        start();
        xfer({`OCR_DEV_ADDR, 1'b0}, 1'b1, rx, a);
        xfer(cmd, 1'b1, rx, a);
        start();
        xfer({`OCR_DEV_ADDR, 1'b1}, 1'b1, rx, a);
        xfer(8'hff, n == 1, dat[7:0], a);
        if (n == 2) xfer(8'hff, 1'b1, dat[15:8], a);
        stop();
    endtask
endmodule

// >>> sim/ocr_fault_response_chk.sv
// Assertions on the ports of the overcurrent fault block
`timescale 1ns/1ps
module ocr_fault_response_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pmbClkPin,
    input wire logic pmbDataOut,
    input wire logic pmbDataDriveB,
    input wire ocr_pkg::ocr_plant_in_t plantIn,
    input wire ocr_pkg::ocr_plant_out_t plantOut
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ****************************************
    // Output sequencing and status
    // ****************************************
    // Off request from the control input or another fault
    sequence s_off_req;
        !plantIn.enableCmd || plantIn.otherFault;
    endsequence
    property p_off_cmd;
        s_off_req |=> !plantOut.outputEnable && !plantOut.currentLimit;
    endproperty
    a_off_cmd: assert property (p_off_cmd)
        else $error("output on after off request");
    property p_run_cause;
        $rose(plantOut.outputEnable) |->
            $past(plantIn.enableCmd) && !$past(plantIn.otherFault);
    endproperty
    a_run_cause: assert property (p_run_cause)
        else $error("output started while commanded off");
    // A shutdown that no command explains must carry the status flag
    property p_shut_flag;
        $fell(plantOut.outputEnable) && $past(plantIn.enableCmd) &&
            !$past(plantIn.otherFault) |-> plantOut.ocFault;
    endproperty
    a_shut_flag: assert property (p_shut_flag)
        else $error("shutdown without fault flag");
    property p_alert;
        plantOut.alertDriveB == !plantOut.ocFault;
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert does not follow fault flag");
    property p_sticky;
        $fell(plantOut.ocFault) |-> $past(plantIn.faultClear);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("fault flag dropped without clear");
    property p_limit_on;
        plantOut.currentLimit |-> plantOut.outputEnable;
    endproperty
    a_limit_on: assert property (p_limit_on)
        else $error("limiting with output off");
    property p_limit_flag;
        $rose(plantOut.currentLimit) |-> plantOut.ocFault;
    endproperty
    a_limit_flag: assert property (p_limit_flag)
        else $error("limiting without fault flag");
    // Data may only move while the bus clock is low
    property p_drive_low;
        $changed(pmbDataDriveB) |-> !pmbClkPin;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("data moved while clock high");
    property p_open_drain;
        !pmbDataOut && !plantOut.alertOut;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain value not low");
endmodule

bind ocr_fault_response ocr_fault_response_chk u_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pmbClkPin(pmbClkPin),
    .pmbDataOut(pmbDataOut),
    .pmbDataDriveB(pmbDataDriveB),
    .plantIn(plantIn),
    .plantOut(plantOut)
);

// >>> sim/ocr_fault_response_tb_top.sv
// Self-checking bench of the overcurrent fault block
`timescale 1ns/1ps
`include "ocr_defs.svh"
module ocr_fault_response_tb_top;
    typedef struct packed {
        logic [7:0] setup;
        logic [15:0] cur;
        logic vLow;
        logic en;
        logic lim;
        logic flt;
    } ocr_row_t;
    logic core_clk = 1'b0;
    logic rst_b;
    logic pmbClkPin, pmbDataIn, pmbDataOut, pmbDataDriveB, ok;
    logic prevEn = 1'b0;
    ocr_pkg::ocr_plant_in_t plantIn;
    ocr_pkg::ocr_plant_out_t plantOut;
    int miscompares = 0;
    int totalChecks = 0;
    int restarts = 0;
    logic [15:0] rdv;
    logic [15:0] expR;
    ocr_row_t rows [7];
    int retr [5] = '{0, 1, 2, 6, 7};
    // ****************************************
    // Clock, design and bus host
    // ****************************************
    always #4 core_clk = ~core_clk;
    ocr_fault_response uut (.core_clk(core_clk), .rst_b(rst_b),
        .pmbClkPin(pmbClkPin), .pmbDataIn(pmbDataIn),
        .pmbDataOut(pmbDataOut), .pmbDataDriveB(pmbDataDriveB),
        .plantIn(plantIn), .plantOut(plantOut));
    ocr_bus_host host (.core_clk(core_clk), .pmbDataOut(pmbDataOut),
        .pmbDataDriveB(pmbDataDriveB), .pmbClkPin(pmbClkPin),
        .pmbDataIn(pmbDataIn));
    // Restart attempts seen as rising edges of the output enable
    always @(posedge core_clk) begin
        if (plantOut.outputEnable && !prevEn) restarts++;
        prevEn <= plantOut.outputEnable;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk1(input logic got, input logic exp, input string m);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                         input string m);
        chk1(got === exp, 1'b1, m);
    endtask
    task automatic put_setup(input logic [7:0] v);
        host.wr(`OCR_DEV_ADDR, `OCR_CMD_SETUP, {8'h00, v}, 1, ok);
        chk1(ok, 1'b1, "setup write not acked");
    endtask
    // Pulses spaced so a restart and its re-fault settle in between
    task automatic ticks(input int n);
        repeat (n) begin
            plantIn.unitTick <= 1'b1;
            cyc(1);
            plantIn.unitTick <= 1'b0;
            cyc(3);
        end
    endtask
    // Off then clear: ends retries and drops the sticky flag
    task automatic recover();
        plantIn.current <= 16'h0000;
        plantIn.voltLow <= 1'b0;
        plantIn.enableCmd <= 1'b0;
        cyc(2);
        plantIn.faultClear <= 1'b1;
        cyc(1);
        plantIn.faultClear <= 1'b0;
        plantIn.enableCmd <= 1'b1;
        cyc(4);
        chk1(plantOut.ocFault, 1'b0, "fault not cleared");
        chk1(plantOut.outputEnable, 1'b1, "output not back");
        restarts = 0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_b <= 1'b0;
        plantIn <= '0;
        rows = '{{8'h00, 16'h0101, 4'b0111}, {8'h00, 16'h0101, 4'b1111},
                 {8'h40, 16'h0101, 4'b0111}, {8'h80, 16'h0101, 4'b0111},
                 {8'hc0, 16'h0101, 4'b0001}, {8'h00, 16'h0100, 4'b0100},
                 {8'hc0, 16'h07ff, 4'b0100}};
        cyc(3);
        rst_b <= 1'b1;
        plantIn.enableCmd <= 1'b1;
        cyc(4);
        chk1(plantOut.outputEnable, 1'b1, "not running");
        host.rd(`OCR_CMD_LIMIT, 2, rdv);
        chk16(rdv, `OCR_LIMIT_RST, "limit reset value");
        host.rd(`OCR_CMD_SETUP, 1, rdv);
        chk16(rdv, {8'h00, `OCR_SETUP_RST}, "setup reset value");
        host.wr(`OCR_DEV_ADDR, `OCR_CMD_LIMIT, 16'h0100, 2, ok);
        host.rd(`OCR_CMD_LIMIT, 2, rdv);
        chk16(rdv, 16'h0100, "limit readback");
        host.wr(`OCR_DEV_ADDR ^ 7'h01, `OCR_CMD_SETUP, 16'h0000, 1, ok);
        chk1(ok, 1'b0, "foreign address acked");
        host.rd(8'h50, 1, rdv);
        chk16(rdv, 16'h0000, "unmapped read");
        // Reaction codes, code 0 at low voltage, the limit boundary and a negative mantissa, one row each
        foreach (rows[i]) begin
            put_setup(rows[i].setup);
            plantIn.current <= rows[i].cur;
            plantIn.voltLow <= rows[i].vLow;
            cyc(2);
            chk1(plantOut.outputEnable, rows[i].en, "row enable");
            chk1(plantOut.currentLimit, rows[i].lim, "row limit");
            chk1(plantOut.ocFault, rows[i].flt, "row fault");
            recover();
        end
        // Conditioned limiting falls to shutdown below the floor
        put_setup(8'h40);
        plantIn.current <= 16'h0101;
        cyc(3);
        plantIn.voltLow <= 1'b1;
        cyc(2);
        chk1(plantOut.outputEnable, 1'b0, "no floor shutdown");
        ticks(3);
        chk16(16'(restarts), 16'h0000, "restart on no retry");
        recover();
        // Delayed limiting ends after exactly 1 << code units
        for (int k = 0; k < 8; k++) begin
            put_setup({5'b10000, 3'(k)});
            plantIn.current <= 16'h0101;
            cyc(2);
            ticks((1 << k) - 1);
            chk1(plantOut.currentLimit, 1'b1, "delay early");
            ticks(1);
            chk1(plantOut.outputEnable, 1'b0, "late end");
            recover();
        end
        // Restart counts under a fault that never goes away
        foreach (retr[j]) begin
            put_setup({2'b11, 3'(retr[j]), 3'b000});
            plantIn.current <= 16'h0101;
            // First shutdown lands before the ticks, so each tick counts
            cyc(2);
            ticks(8);
            expR = retr[j] == 7 ? 16'h0008 : 16'(retr[j]);
            chk16(16'(restarts), expR, "restarts");
            chk1(plantOut.outputEnable, 1'b0, "not latched off");
            plantIn.otherFault <= 1'b1;
            ticks(3);
            chk16(16'(restarts), expR, "retry after other fault");
            plantIn.otherFault <= 1'b0;
            recover();
        end
        // Mid-run reset drops the output and restores the settings
        rst_b <= 1'b0;
        cyc(3);
        chk1(plantOut.outputEnable, 1'b0, "enable in reset");
        chk1(pmbDataDriveB, 1'b1, "bus held in reset");
        rst_b <= 1'b1;
        cyc(4);
        chk1(plantOut.outputEnable, 1'b1, "no run after reset");
        host.rd(`OCR_CMD_SETUP, 1, rdv);
        chk16(rdv, {8'h00, `OCR_SETUP_RST}, "setup after reset");
        report_and_stop();
    end
    // Bounded run: a hang counts as a mismatch
    initial begin
        cyc(100000);
        miscompares++;
        report_and_stop();
    end
endmodule
